// ### rtl/tcstat_defines.vh
// Purpose : Shared constants for the cell statistics and mode block
// Assumes : Byte-wide register port, 10-bit register address
// Notes   : Offsets are byte addresses of the register port
`ifndef TCSTAT_DEFINES_VH
`define TCSTAT_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TCSTAT_ADDR_W          10
`define TCSTAT_OFS_FIXED_HEC   10'h037
`define TCSTAT_OFS_RX_LOW      10'h038
`define TCSTAT_OFS_RX_MID      10'h039
`define TCSTAT_OFS_RX_HIGH     10'h03A
`define TCSTAT_OFS_BAD_HEC     10'h03B
`define TCSTAT_OFS_SCREEN_LOW  10'h03C
`define TCSTAT_OFS_SCREEN_HIGH 10'h03D
`define TCSTAT_OFS_EVT_STATUS  10'h03F
`define TCSTAT_OFS_MODE        10'h200

// ----------------------------------------------------------------
// Counter widths and saturation values
// ----------------------------------------------------------------
`define TCSTAT_CNT_W           19
`define TCSTAT_MAX_BYTE        19'h000FF
`define TCSTAT_MAX_RX          19'h7FFFF
`define TCSTAT_MAX_SCREEN      19'h0FFFF

// ----------------------------------------------------------------
// Mode register fields and reset value
// ----------------------------------------------------------------
`define TCSTAT_MODE_RST        8'h00
`define TCSTAT_MODE_WMASK      8'hF9
`define TCSTAT_BIT_MASTER_RST  7
`define TCSTAT_BIT_LOGIC_RST   6
`define TCSTAT_BIT_STAT_LAT    5
`define TCSTAT_BIT_CNTR_LAT    4
`define TCSTAT_BIT_IRQ_EN      3
`define TCSTAT_BIT_SEC_DRIVE   0

// ----------------------------------------------------------------
// Event status bits
// ----------------------------------------------------------------
`define TCSTAT_ST_W            4
`define TCSTAT_ST_RST          4'h0

// ----------------------------------------------------------------
// One-second timing: 8000 periods of the 8 kHz tick
// ----------------------------------------------------------------
`define TCSTAT_TICK_KHZ        8
`define TCSTAT_SEC_MS          1000
`define TCSTAT_SEC_TICKS       (`TCSTAT_TICK_KHZ * `TCSTAT_SEC_MS)
`define TCSTAT_DIV_W           13

`endif

// ### rtl/tcstat_top.v
// Purpose : Cell statistics counters, event status and device mode
//           control of the transmission-convergence receive side
// Assumes : All inputs synchronous to clk_sys; event inputs are
//           one-cycle pulses; tick_8k is a one-cycle 8 kHz enable
// Notes   : Summary of behaviour follows below
//
// Summary of operation
// - Count corrected HEC errors, 8 bits, at 0x37
// - Count received cells, 19 bits, from 0x38
// - Upper rx count byte bits 7..3 read zero
// - Count uncorrectable HEC errors, 8 bits, at 0x3B
// - Count screen rejects, 16 bits, at 0x3C/0x3D
// - Reading a counter returns it then clears it
// - Master reset holds logic, defaults all registers
// - Logic reset holds logic, keeps register contents
// - Latched status shows last one-second interval only
// - Latched status read clears until next second
// - Unlatched status accumulates since last read
// - Latched counters show last one-second interval count
// - Latched counter read clears until next second
// - Unlatched counters count since last read
// - Mode bit 3 gates the interrupt pin
// - Drive mode: 8000 ticks make a second pulse
// - Unlatched event status reports events since last read
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`include "tcstat_defines.vh"

module tcstat_top
#(
  parameter SEC_TICKS = `TCSTAT_SEC_TICKS // 8 kHz ticks per second
)
(
  input  wire                      clk_sys,
  input  wire                      rst_n,
  input  wire [`TCSTAT_ADDR_W-1:0] reg_addr,
  input  wire [7:0]                reg_wdata,
  input  wire                      reg_wr,
  input  wire                      reg_rd,
  output reg  [7:0]                reg_rdata,
  input  wire                      fixed_hec_evt,
  input  wire                      bad_hec_evt,
  input  wire                      rx_cell_evt,
  input  wire                      screen_reject_evt,
  input  wire                      irq_source,
  input  wire                      tick_8k,
  input  wire                      second_pulse_pin_in,
  output reg                       second_pulse_pin_out,
  output reg                       second_pulse_pin_oe,
  output reg                       host_irq_n,
  output reg                       logic_hold,
  output reg                       second_evt
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [7:0]               mode_ff;        // Mode control
  reg  [7:0]               nxt_mode;       // Next mode value
  reg  [`TCSTAT_CNT_W-1:0] fix_vis_ff;     // Visible corrected HEC count
  reg  [`TCSTAT_CNT_W-1:0] fix_acc_ff;     // Pending corrected HEC count
  reg  [`TCSTAT_CNT_W-1:0] rx_vis_ff;      // Visible rx cell count
  reg  [`TCSTAT_CNT_W-1:0] rx_acc_ff;      // Pending rx cell count
  reg  [`TCSTAT_CNT_W-1:0] bad_vis_ff;     // Visible bad HEC count
  reg  [`TCSTAT_CNT_W-1:0] bad_acc_ff;     // Pending bad HEC count
  reg  [`TCSTAT_CNT_W-1:0] scr_vis_ff;     // Visible screen reject count
  reg  [`TCSTAT_CNT_W-1:0] scr_acc_ff;     // Pending screen reject count
  reg  [15:0]              rx_hold_ff;     // Rx mid/high snapshot
  reg  [7:0]               scr_hold_ff;    // Screen high snapshot
  reg  [`TCSTAT_ST_W-1:0]  st_vis_ff;      // Visible event status
  reg  [`TCSTAT_ST_W-1:0]  st_acc_ff;      // Pending event status
  reg  [`TCSTAT_DIV_W-1:0] div_ff;         // 8 kHz tick divider
  reg                      pin_prev_ff;    // Pin level last cycle
  reg  [7:0]               nxt_rdata;      // Read mux result

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  wire master_rst = mode_ff[`TCSTAT_BIT_MASTER_RST];
  wire hold       = master_rst | mode_ff[`TCSTAT_BIT_LOGIC_RST];
  wire stat_lat   = mode_ff[`TCSTAT_BIT_STAT_LAT];
  wire cntr_lat   = mode_ff[`TCSTAT_BIT_CNTR_LAT];
  wire drive_sec  = mode_ff[`TCSTAT_BIT_SEC_DRIVE];

  // Event inputs are ignored while the block logic is held
  wire ev_fix = fixed_hec_evt & ~hold;
  wire ev_rx  = rx_cell_evt & ~hold;
  wire ev_bad = bad_hec_evt & ~hold;
  wire ev_scr = screen_reject_evt & ~hold;

  // Read strobes per register, and the mode write strobe
  wire rd_fix   = reg_rd & (reg_addr == `TCSTAT_OFS_FIXED_HEC);
  wire rd_rx_l  = reg_rd & (reg_addr == `TCSTAT_OFS_RX_LOW);
  wire rd_rx_m  = reg_rd & (reg_addr == `TCSTAT_OFS_RX_MID);
  wire rd_rx_h  = reg_rd & (reg_addr == `TCSTAT_OFS_RX_HIGH);
  wire rd_bad   = reg_rd & (reg_addr == `TCSTAT_OFS_BAD_HEC);
  wire rd_scr_l = reg_rd & (reg_addr == `TCSTAT_OFS_SCREEN_LOW);
  wire rd_scr_h = reg_rd & (reg_addr == `TCSTAT_OFS_SCREEN_HIGH);
  wire rd_st    = reg_rd & (reg_addr == `TCSTAT_OFS_EVT_STATUS);
  wire wr_mode  = reg_wr & (reg_addr == `TCSTAT_OFS_MODE);

  // ----------------------------------------------------------------
  // One-second event source
  // ----------------------------------------------------------------
  // Terminal count of the internal divider
  wire div_end  = tick_8k &
                  ({{(32-`TCSTAT_DIV_W){1'b0}}, div_ff} == SEC_TICKS - 1);
  // Rising edge of the pin in receive mode
  wire pin_rise = second_pulse_pin_in & ~pin_prev_ff;
  // Selected one-second event for this cycle
  wire sec_now  = ~hold & (drive_sec ? div_end : pin_rise);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Saturating increment; stops at the counter's all-ones value
  function [`TCSTAT_CNT_W-1:0] sat_inc;
    input [`TCSTAT_CNT_W-1:0] val;
    input                     evt;
    input [`TCSTAT_CNT_W-1:0] max;
    begin
      sat_inc = (evt && (val != max)) ? val + 1'b1 : val;
    end
  endfunction

  // Next visible count. Event beats a clearing read, so a pulse
  // in the read cycle still lands in the fresh count.
  function [`TCSTAT_CNT_W-1:0] next_vis;
    input [`TCSTAT_CNT_W-1:0] vis;
    input [`TCSTAT_CNT_W-1:0] acc;
    input                     evt;
    input                     clr;
    input                     lat;
    input                     sec;
    input [`TCSTAT_CNT_W-1:0] max;
    reg   [`TCSTAT_CNT_W-1:0] base;
    begin
      base = clr ? {`TCSTAT_CNT_W{1'b0}} : vis;
      if (lat)
      begin
        // Interval count replaces view only on a second
        if (sec)
          next_vis = acc;
        else
          next_vis = base;
      end
      else
        next_vis = sat_inc(base, evt, max);
    end
  endfunction

  // Next pending interval count, used only while latching
  function [`TCSTAT_CNT_W-1:0] next_acc;
    input [`TCSTAT_CNT_W-1:0] acc;
    input                     evt;
    input                     lat;
    input                     sec;
    input [`TCSTAT_CNT_W-1:0] max;
    begin
      if (!lat)
        next_acc = {`TCSTAT_CNT_W{1'b0}};
      else if (sec)
        next_acc = sat_inc({`TCSTAT_CNT_W{1'b0}}, evt, max);
      else
        next_acc = sat_inc(acc, evt, max);
    end
  endfunction

  // ----------------------------------------------------------------
  // Mode register next value
  // ----------------------------------------------------------------
  // While master reset is set, every other bit is held at default
  always @*
  begin
    nxt_mode = mode_ff;
    if (wr_mode)
      nxt_mode = reg_wdata & `TCSTAT_MODE_WMASK;
    if (nxt_mode[`TCSTAT_BIT_MASTER_RST])
      nxt_mode = `TCSTAT_MODE_RST |
                 (8'h01 << `TCSTAT_BIT_MASTER_RST);
  end

  // ----------------------------------------------------------------
  // Mode register and pin control
  // ----------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ff             <= `TCSTAT_MODE_RST;
      second_pulse_pin_oe <= 1'b0;
      logic_hold          <= 1'b0;
    end
    else
    begin
      mode_ff             <= nxt_mode;
      // Pin drives only in internal mode
      second_pulse_pin_oe <= nxt_mode[`TCSTAT_BIT_SEC_DRIVE];
      // Downstream state machines held in either reset mode
      logic_hold          <= nxt_mode[`TCSTAT_BIT_MASTER_RST] |
                             nxt_mode[`TCSTAT_BIT_LOGIC_RST];
    end
  end

  // ----------------------------------------------------------------
  // One-second divider and pin pulse
  // ----------------------------------------------------------------
  // Divider is a state machine, so both resets hold it at zero
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_ff               <= {`TCSTAT_DIV_W{1'b0}};
      pin_prev_ff          <= 1'b0;
      second_pulse_pin_out <= 1'b0;
      second_evt           <= 1'b0;
    end
    else if (hold)
    begin
      div_ff               <= {`TCSTAT_DIV_W{1'b0}};
      pin_prev_ff          <= 1'b0;
      second_pulse_pin_out <= 1'b0;
      second_evt           <= 1'b0;
    end
    else
    begin
      // Count only 8 kHz ticks while driving the pin
      if (!drive_sec || div_end)
        div_ff <= {`TCSTAT_DIV_W{1'b0}};
      else if (tick_8k)
        div_ff <= div_ff + 1'b1;
      pin_prev_ff          <= second_pulse_pin_in;
      // One-cycle high pulse: low-high-low on the pin
      second_pulse_pin_out <= drive_sec & div_end;
      second_evt           <= sec_now;
    end
  end

  // ----------------------------------------------------------------
  // Statistics counters
  // ----------------------------------------------------------------
  // Counters live in register space, so only master reset clears
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fix_vis_ff  <= {`TCSTAT_CNT_W{1'b0}};
      fix_acc_ff  <= {`TCSTAT_CNT_W{1'b0}};
      rx_vis_ff   <= {`TCSTAT_CNT_W{1'b0}};
      rx_acc_ff   <= {`TCSTAT_CNT_W{1'b0}};
      bad_vis_ff  <= {`TCSTAT_CNT_W{1'b0}};
      bad_acc_ff  <= {`TCSTAT_CNT_W{1'b0}};
      scr_vis_ff  <= {`TCSTAT_CNT_W{1'b0}};
      scr_acc_ff  <= {`TCSTAT_CNT_W{1'b0}};
      rx_hold_ff  <= 16'h0000;
      scr_hold_ff <= 8'h00;
    end
    else if (master_rst)
    begin
      fix_vis_ff  <= {`TCSTAT_CNT_W{1'b0}};
      fix_acc_ff  <= {`TCSTAT_CNT_W{1'b0}};
      rx_vis_ff   <= {`TCSTAT_CNT_W{1'b0}};
      rx_acc_ff   <= {`TCSTAT_CNT_W{1'b0}};
      bad_vis_ff  <= {`TCSTAT_CNT_W{1'b0}};
      bad_acc_ff  <= {`TCSTAT_CNT_W{1'b0}};
      scr_vis_ff  <= {`TCSTAT_CNT_W{1'b0}};
      scr_acc_ff  <= {`TCSTAT_CNT_W{1'b0}};
      rx_hold_ff  <= 16'h0000;
      scr_hold_ff <= 8'h00;
    end
    else
    begin
      // Corrected HEC, single byte
      fix_vis_ff <= next_vis(fix_vis_ff, fix_acc_ff, ev_fix, rd_fix,
                             cntr_lat, sec_now, `TCSTAT_MAX_BYTE);
      fix_acc_ff <= next_acc(fix_acc_ff, ev_fix, cntr_lat, sec_now,
                             `TCSTAT_MAX_BYTE);
      // Received cells, 19 bits; low byte read clears all of it
      rx_vis_ff  <= next_vis(rx_vis_ff, rx_acc_ff, ev_rx, rd_rx_l,
                             cntr_lat, sec_now, `TCSTAT_MAX_RX);
      rx_acc_ff  <= next_acc(rx_acc_ff, ev_rx, cntr_lat, sec_now,
                             `TCSTAT_MAX_RX);
      // Uncorrectable HEC, single byte
      bad_vis_ff <= next_vis(bad_vis_ff, bad_acc_ff, ev_bad, rd_bad,
                             cntr_lat, sec_now, `TCSTAT_MAX_BYTE);
      bad_acc_ff <= next_acc(bad_acc_ff, ev_bad, cntr_lat, sec_now,
                             `TCSTAT_MAX_BYTE);
      // Screen rejects, 16 bits
      scr_vis_ff <= next_vis(scr_vis_ff, scr_acc_ff, ev_scr, rd_scr_l,
                             cntr_lat, sec_now, `TCSTAT_MAX_SCREEN);
      scr_acc_ff <= next_acc(scr_acc_ff, ev_scr, cntr_lat, sec_now,
                             `TCSTAT_MAX_SCREEN);
      // Snapshot upper bytes so the later reads agree with low byte
      if (rd_rx_l)
        rx_hold_ff <= {5'h00, rx_vis_ff[18:8]};
      else if (rd_rx_m)
        rx_hold_ff[7:0] <= 8'h00;
      else if (rd_rx_h)
        rx_hold_ff[15:8] <= 8'h00;                     // Each byte clears after its read
      if (rd_scr_l)
        scr_hold_ff <= scr_vis_ff[15:8];
      else if (rd_scr_h)
        scr_hold_ff <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Event status register
  // ----------------------------------------------------------------
  // Bit order: corrected, uncorrected, received, screened
  wire [`TCSTAT_ST_W-1:0] st_evt = {ev_fix, ev_bad, ev_rx, ev_scr};

  // Latched mode shows the interval; unlatched mode is sticky
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_vis_ff <= `TCSTAT_ST_RST;
      st_acc_ff <= `TCSTAT_ST_RST;
    end
    else if (master_rst)
    begin
      st_vis_ff <= `TCSTAT_ST_RST;
      st_acc_ff <= `TCSTAT_ST_RST;
    end
    else if (stat_lat)
    begin
      // Pending bits publish only on the second event
      if (sec_now)
      begin
        st_vis_ff <= st_acc_ff;
        st_acc_ff <= st_evt;
      end
      else
      begin
        if (rd_st)
          st_vis_ff <= `TCSTAT_ST_RST;
        st_acc_ff <= st_acc_ff | st_evt;
      end
    end
    else
    begin
      // Set wins over a clearing read in the same cycle
      st_vis_ff <= (rd_st ? `TCSTAT_ST_RST : st_vis_ff) | st_evt;
      st_acc_ff <= `TCSTAT_ST_RST;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  // Pin idles high unless enabled and a source is pending
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      host_irq_n <= 1'b1;
    else
      host_irq_n <= ~(nxt_mode[`TCSTAT_BIT_IRQ_EN] & irq_source);
  end

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  always @*
  begin
    nxt_rdata = 8'h00;
    case (reg_addr)
      `TCSTAT_OFS_FIXED_HEC:   nxt_rdata = fix_vis_ff[7:0];
      `TCSTAT_OFS_RX_LOW:      nxt_rdata = rx_vis_ff[7:0];
      `TCSTAT_OFS_RX_MID:      nxt_rdata = rx_hold_ff[7:0];
      `TCSTAT_OFS_RX_HIGH:     nxt_rdata = {5'h00, rx_hold_ff[10:8]};
      `TCSTAT_OFS_BAD_HEC:     nxt_rdata = bad_vis_ff[7:0];
      `TCSTAT_OFS_SCREEN_LOW:  nxt_rdata = scr_vis_ff[7:0];
      `TCSTAT_OFS_SCREEN_HIGH: nxt_rdata = scr_hold_ff;
      `TCSTAT_OFS_EVT_STATUS:  nxt_rdata = {4'h0, st_vis_ff};
      `TCSTAT_OFS_MODE:        nxt_rdata = mode_ff;
      default:                 nxt_rdata = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Data stands only in the cycle after the read strobe
  always @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_rd ? nxt_rdata : 8'h00;
  end

endmodule // tcstat_top

// ### verification/tcstat_checker_sva.sv
// Purpose : Port-level checks of the cell statistics block
// Assumes : One clock, asynchronous active-low reset
// Notes   : Bound into tcstat_top at the foot of this file
`timescale 1ns/1ps
`include "tcstat_defines.vh"

module tcstat_checker
#(
  parameter SEC_TICKS = 8000 // Ticks per second
)
(
  input wire                      clk_sys,
  input wire                      rst_n,
  input wire [`TCSTAT_ADDR_W-1:0] reg_addr,
  input wire [7:0]                reg_wdata,
  input wire                      reg_wr,
  input wire                      reg_rd,
  input wire [7:0]                reg_rdata,
  input wire                      irq_source,
  input wire                      second_pulse_pin_in,
  input wire                      second_pulse_pin_out,
  input wire                      second_pulse_pin_oe,
  input wire                      host_irq_n,
  input wire                      logic_hold,
  input wire                      second_evt
);
  // ----------------------------------------
  // Shadow of the interrupt enable bit
  // ----------------------------------------
  reg  irq_en_ff;                                     // Mode bit 3 as written
  wire mode_wr = reg_wr && (reg_addr == `TCSTAT_OFS_MODE); // Mode write
  // A master reset write discards the other bits
  always @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      irq_en_ff <= 1'b0;
    else if (mode_wr)
      irq_en_ff <= reg_wdata[7] ? 1'b0 : reg_wdata[3];

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_RDATA_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_RX_HIGH_ZERO: assert property (reg_rd && reg_addr == `TCSTAT_OFS_RX_HIGH |=> reg_rdata[7:3] == 5'h00)
    else $error("reserved upper rx bits not zero");
  AST_OE_FOLLOWS: assert property (mode_wr |=>
    second_pulse_pin_oe == (!$past(reg_wdata[7]) && $past(reg_wdata[0])))
    else $error("pin drive enable does not follow mode");
  AST_HOLD_FOLLOWS: assert property (mode_wr |=> logic_hold == ($past(reg_wdata[7]) || $past(reg_wdata[6])))
    else $error("logic hold does not follow mode");
  AST_IRQ_MASKED: assert property (!irq_en_ff && !$past(irq_en_ff) && !$past(irq_en_ff, 2) |-> host_irq_n)
    else $error("interrupt pin active while disabled");
  AST_IRQ_ACTIVE: assert property (irq_en_ff && $past(irq_en_ff) && $past(irq_en_ff, 2) && irq_source
    && $past(irq_source) && !logic_hold |-> !host_irq_n)
    else $error("interrupt pin idle while enabled and requested");
  AST_PULSE_SINGLE: assert property (second_pulse_pin_out |=> !second_pulse_pin_out)
    else $error("second pulse longer than one cycle");
  AST_PULSE_DRIVEN: assert property (second_pulse_pin_out |-> second_pulse_pin_oe && second_evt)
    else $error("second pulse without drive or event");
  AST_SEC_FROM_PIN: assert property (!second_pulse_pin_oe && !$past(second_pulse_pin_oe) && !logic_hold
    && $rose(second_pulse_pin_in) |-> ##[1:2] second_evt)
    else $error("pin pulse gave no second event");
  AST_HOLD_QUIET: assert property (logic_hold && $past(logic_hold) |-> !second_pulse_pin_out && !second_evt)
    else $error("second event during a reset hold");
endmodule // tcstat_checker

bind tcstat_top tcstat_checker #(.SEC_TICKS(SEC_TICKS)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_source(irq_source),
  .second_pulse_pin_in(second_pulse_pin_in), .second_pulse_pin_out(second_pulse_pin_out),
  .second_pulse_pin_oe(second_pulse_pin_oe), .host_irq_n(host_irq_n),
  .logic_hold(logic_hold), .second_evt(second_evt));

// ### verification/tcstat_top_tb.sv
// Purpose : Self-checking bench of the cell statistics block
// Assumes : Shortened one-second divider to keep the run brief
// Notes   : All inputs change by non-blocking assignment on rising edges
`timescale 1ns/1ps
`include "tcstat_defines.vh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("BAD %s expected %h seen %h", nm, exp, got); end end

module tcstat_top_tb;
  localparam TICKS = 4;          // Ticks per shortened second
  reg        clk_sys;            // 50 MHz clock
  reg        rst_n;              // Active-low reset
  reg  [9:0] reg_addr;           // Register address
  reg  [7:0] reg_wdata;          // Write data
  reg        reg_wr;             // Write strobe
  reg        reg_rd;             // Read strobe
  wire [7:0] reg_rdata;          // Read data
  reg  [3:0] evt_v;              // Fixed, bad, rx, screen events
  reg        irq_source;         // Summary request
  reg        tick_8k;            // Divider tick
  reg        pin_drv;            // Outside party on the pin
  wire       pin_out;            // Pin driven by the block
  wire       pin_oe;             // Block drives the pin
  wire       pin_wire;           // Resolved pin level
  wire       host_irq_n;         // Interrupt pin
  wire       logic_hold;         // Reset hold
  wire       second_evt;         // One-second event
  integer    fail_count;         // Mismatches
  integer    samples_checked;    // Comparisons
  integer    pulses;             // Pin pulses seen
  integer    secs;               // Second events seen

  // Whoever drives wins; outside party stays off while block drives
  assign pin_wire = pin_oe ? pin_out : pin_drv;

  tcstat_top #(.SEC_TICKS(TICKS)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .fixed_hec_evt(evt_v[3]), .bad_hec_evt(evt_v[2]), .rx_cell_evt(evt_v[1]),
    .screen_reject_evt(evt_v[0]), .irq_source(irq_source), .tick_8k(tick_8k),
    .second_pulse_pin_in(pin_wire), .second_pulse_pin_out(pin_out),
    .second_pulse_pin_oe(pin_oe), .host_irq_n(host_irq_n),
    .logic_hold(logic_hold), .second_evt(second_evt));

  // ----------------------------------------
  // Clock and pulse tallies
  // ----------------------------------------
  always #10 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    if (pin_out === 1'b1) pulses = pulses + 1;
    if (second_evt === 1'b1) secs = secs + 1;
  end

  // ----------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------
  task wr(input [9:0] a, input [7:0] d);
  begin
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  end
  endtask

  // Data stand only in the cycle after the strobe
  task rd(input [9:0] a, input [7:0] exp, input string nm);
  begin
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    `CHK(nm, exp, reg_rdata)
  end
  endtask

  // Separate one-cycle pulses, so each counts once
  task fire(input [3:0] m, input integer n);
  begin
    repeat (n)
    begin
      @(posedge clk_sys);
      evt_v <= m;
      @(posedge clk_sys);
      evt_v <= 4'h0;
    end
  end
  endtask

  task tick(input integer n);
  begin
    repeat (n)
    begin
      @(posedge clk_sys);
      tick_8k <= 1'b1;
      @(posedge clk_sys);
      tick_8k <= 1'b0;
    end
  end
  endtask

  // Low-high-low from the outside party
  task pin_pulse;
  begin
    @(posedge clk_sys);
    pin_drv <= 1'b1;
    repeat (2) @(posedge clk_sys);
    pin_drv <= 1'b0;
    repeat (3) @(posedge clk_sys);
  end
  endtask

  task give_verdict;
  begin
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask

  // ----------------------------------------
  // Watchdog, far beyond the expected run
  // ----------------------------------------
  initial
  begin
    #200000;
    fail_count = fail_count + 1;
    give_verdict;
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk_sys = 1'b0; rst_n = 1'b0; reg_addr = 10'h000; reg_wdata = 8'h00; reg_wr = 1'b0;
    reg_rd = 1'b0; evt_v = 4'h0; irq_source = 1'b0; tick_8k = 1'b0; pin_drv = 1'b0;
    fail_count = 0; samples_checked = 0; pulses = 0; secs = 0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(negedge clk_sys) `CHK("irq idle", 1'b1, host_irq_n)
    rd(`TCSTAT_OFS_MODE, 8'h00, "mode reset");
    fire(4'h8, 3);
    fire(4'h4, 5);
    rd(`TCSTAT_OFS_FIXED_HEC, 8'h03, "fixed");
    rd(`TCSTAT_OFS_FIXED_HEC, 8'h00, "fixed cleared");
    rd(`TCSTAT_OFS_BAD_HEC, 8'h05, "bad");
    // Upper bytes must come from the snapshot of the low read
    fire(4'h3, 300);
    rd(`TCSTAT_OFS_RX_LOW, 8'h2C, "rx low");
    fire(4'h2, 256);
    rd(`TCSTAT_OFS_RX_MID, 8'h01, "rx mid");
    rd(`TCSTAT_OFS_RX_HIGH, 8'h00, "rx high");
    rd(`TCSTAT_OFS_RX_LOW, 8'h00, "rx low again");
    rd(`TCSTAT_OFS_RX_MID, 8'h01, "rx mid again");
    rd(`TCSTAT_OFS_SCREEN_LOW, 8'h2C, "screen low");
    rd(`TCSTAT_OFS_SCREEN_HIGH, 8'h01, "screen high");
    fire(4'h8, 260);
    rd(`TCSTAT_OFS_FIXED_HEC, 8'hFF, "saturated");
    rd(`TCSTAT_OFS_EVT_STATUS, 8'h0F, "status all");
    rd(`TCSTAT_OFS_EVT_STATUS, 8'h00, "status cleared");
    fire(4'h5, 1);
    rd(`TCSTAT_OFS_EVT_STATUS, 8'h05, "status again");
    rd(`TCSTAT_OFS_BAD_HEC, 8'h01, "bad one");
    wr(10'h03E, 8'hAA);
    rd(10'h03E, 8'h00, "unmapped");
    @(posedge clk_sys) irq_source <= 1'b1;
    wr(`TCSTAT_OFS_MODE, 8'h0E);
    rd(`TCSTAT_OFS_MODE, 8'h08, "reserved mode bits");
    `CHK("irq on", 1'b0, host_irq_n)
    wr(`TCSTAT_OFS_MODE, 8'h00);
    repeat (3) @(negedge clk_sys);
    `CHK("irq gated", 1'b1, host_irq_n)
    @(posedge clk_sys) irq_source <= 1'b0;
    wr(`TCSTAT_OFS_MODE, 8'h01);
    pulses = 0;
    secs = 0;
    tick(2 * TICKS);
    repeat (3) @(posedge clk_sys);
    `CHK("drive pulses", 2, pulses)
    `CHK("drive seconds", 2, secs)
    // Latching both kinds, seconds made inside
    wr(`TCSTAT_OFS_MODE, 8'h31);
    tick(TICKS);
    fire(4'h8, 3);
    rd(`TCSTAT_OFS_FIXED_HEC, 8'h00, "latched early");
    rd(`TCSTAT_OFS_EVT_STATUS, 8'h00, "status early");
    tick(TICKS);
    rd(`TCSTAT_OFS_FIXED_HEC, 8'h03, "latched count");
    rd(`TCSTAT_OFS_FIXED_HEC, 8'h00, "latched cleared");
    rd(`TCSTAT_OFS_EVT_STATUS, 8'h08, "latched status");
    rd(`TCSTAT_OFS_EVT_STATUS, 8'h00, "status held");
    // Seconds from the outside party
    wr(`TCSTAT_OFS_MODE, 8'h10);
    secs = 0;
    pin_pulse;
    fire(4'h4, 2);
    rd(`TCSTAT_OFS_BAD_HEC, 8'h00, "pin early");
    pin_pulse;
    rd(`TCSTAT_OFS_BAD_HEC, 8'h02, "pin count");
    `CHK("pin seconds", 2, secs)
    wr(`TCSTAT_OFS_MODE, 8'h00);
    fire(4'h4, 4);
    wr(`TCSTAT_OFS_MODE, 8'h48);
    @(negedge clk_sys) `CHK("logic hold", 1'b1, logic_hold)
    fire(4'h8, 2);
    rd(`TCSTAT_OFS_MODE, 8'h48, "mode kept");
    wr(`TCSTAT_OFS_MODE, 8'h00);
    rd(`TCSTAT_OFS_BAD_HEC, 8'h04, "count kept");
    rd(`TCSTAT_OFS_FIXED_HEC, 8'h00, "held events");
    fire(4'h4, 3);
    wr(`TCSTAT_OFS_MODE, 8'h89);
    @(negedge clk_sys) `CHK("master hold", 1'b1, logic_hold)
    rd(`TCSTAT_OFS_MODE, 8'h80, "master mode");
    wr(`TCSTAT_OFS_MODE, 8'h00);
    rd(`TCSTAT_OFS_BAD_HEC, 8'h00, "master count");
    rd(`TCSTAT_OFS_EVT_STATUS, 8'h00, "master status");
    give_verdict;
  end
endmodule // tcstat_top_tb
